// File: hdl/phy_reset_carrier_link_loopback.v
// Purpose: reset sequencing, carrier sense, collision, link monitor and loopback control
// Assumes: 100 MHz sys_clk_in; pins from the line side and MAC side are asynchronous
// Notes:   a small register port holds control, mode and status bits
//
// Summary of operation
// - Hardware reset returns the registers to defaults; software reset does so except for mode bits 7:4.
// - Preserved bits keep their value over a software reset only.
// - MAC interface runs slow for 16 us after reset, then fast if negotiating.
// - Writing one to soft reset starts a reset; the bit then clears itself.
// - Software reset completes well within half a second.
// - Carrier goes to the MII carrier output or the RMII carrier/valid output.
// - Full-duplex or repeater: carrier from receive only; else transmit or receive.
// - Two zeros, adjacent or not, within ten received bits raise carrier.
// - Ten consecutive ones before start delimiter drop carrier.
// - After start pair carrier holds until the end symbol or first idle; it returns unless end pair or two idles follow.
// - Collision shows concurrent transmit and receive; never in full duplex.
// - Collision test: collision follows transmit enable within the bit-time bounds.
// - Link status is the 100 or 10 Mbps link, by speed, to bit and indicator.
// - Valid data leads to link-ready when negotiating, then link-up on negotiation enable; else straight to link-up.
// - Link monitor waits 330 us of valid data before link-ready.
// - Loss of valid data drops the 100 Mbps link at once from any state.
// - Near loopback returns transmit data, powers transmitters down, masks collision unless collision test is on.
// - Far loopback only works in RMII mode.
// - Far loopback returns line data to the partner and isolates the MAC.
//
// The placing of the registers and the strobed register port were decided locally.
`include "phy_ctl_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module phy_reset_carrier_link_loopback #(
  parameter SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter SLOW_CYCLES   = `SLOW_CYCLES
) (
  input  wire       sys_clk_in,
  input  wire       rstn_in,
  input  wire       hw_reset_low_pin_in,
  input  wire [3:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  input  wire       reduced_iface_strap_in,
  input  wire       tx_en_in,
  input  wire [3:0] txd_in,
  input  wire       rx_bit_in,
  input  wire       rx_sym_valid_in,
  input  wire [4:0] rx_sym_in,
  input  wire [3:0] rx_line_data_in,
  input  wire       data_valid_in,
  input  wire       link10_in,
  input  wire       an_enable_link_in,
  output reg        crs_out,
  output reg        crs_dv_out,
  output reg        col_out,
  output reg  [3:0] rxd_out,
  output reg  [3:0] line_txd_out,
  output reg        line_tx_power_out,
  output reg        link_indicator_output_out,
  output reg        mac_isolate_out,
  output reg        mac_fast_clk_out,
  output reg        in_reset_out
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // First stages are read only by their second stages
  reg [9:0] s1;
  reg [9:0] s2;
  always @(posedge sys_clk_in)
  begin
    s1 <= {hw_reset_low_pin_in, reduced_iface_strap_in, tx_en_in, rx_bit_in,
           rx_sym_valid_in, data_valid_in, link10_in, an_enable_link_in, 2'b00};
    s2 <= s1;
  end
  wire hw_rst_n  = s2[9];
  wire rmii_sel  = s2[8];
  wire tx_en     = s2[7];
  wire rx_bit    = s2[6];
  wire sym_vld   = s2[5];
  wire dvalid    = s2[4];
  wire link10    = s2[3];
  wire an_ok     = s2[2];
  reg  [4:0] sym_q1;
  reg  [4:0] sym_q2;
  always @(posedge sys_clk_in)
  begin
    sym_q1 <= rx_sym_in;
    sym_q2 <= sym_q1;
  end

  // ----------------------------------------------------------------
  // Reset control
  // ----------------------------------------------------------------
  reg  [7:0] ctrl;
  reg  [7:0] mode;
  reg  [2:0] srst_cnt;
  wire       srst_act = ctrl[`CTRL_SOFT_RESET];
  wire       hard_rst = !rstn_in || !hw_rst_n;
  // Soft reset drives the same internal reset as the pin
  wire       int_rst  = hard_rst || (srst_act && srst_cnt == (`SRST_CYCLES - 1));
  always @(posedge sys_clk_in)
  begin
    if (hard_rst || !srst_act)
      srst_cnt <= 3'h0;
    else if (srst_cnt != 3'h7)
      srst_cnt <= srst_cnt + 3'h1;
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire [7:0] status;
  always @(posedge sys_clk_in)
  begin
    if (hard_rst)
    begin
      ctrl <= `CTRL_RESET_VAL;
      mode <= `MODE_RESET_VAL;
    end
    else if (int_rst)
    begin
      ctrl <= `CTRL_RESET_VAL;
      // Upper mode bits survive software reset
      mode <= {mode[7:`MODE_USER_BITS], 4'h0};
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `ADDR_CTRL)
        ctrl <= {1'b0, reg_wdata_in[6:1], reg_wdata_in[0] | srst_act};
      else if (reg_addr_in == `ADDR_MODE)
        mode <= reg_wdata_in;
    end
  end
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      if (reg_addr_in == `ADDR_CTRL)
        reg_rdata_out <= ctrl;
      else if (reg_addr_in == `ADDR_MODE)
        reg_rdata_out <= mode;
      else if (reg_addr_in == `ADDR_STAT)
        reg_rdata_out <= status;
      else
        reg_rdata_out <= 8'h00;
    end
    else
      reg_rdata_out <= 8'h00;
  end
  wire col_test = ctrl[`CTRL_COL_TEST];
  wire near_lb  = ctrl[`CTRL_LOOPBACK];
  wire an_en    = ctrl[`CTRL_AN_ENABLE];
  wire fdx      = ctrl[`CTRL_FULL_DUPLEX];
  wire spd100   = ctrl[`CTRL_SPEED_100];
  wire rptr     = ctrl[`CTRL_REPEATER];
  wire far_lb   = mode[`MODE_REMOTE_LOOP] && rmii_sel;

  // ----------------------------------------------------------------
  // Slow interface window after reset
  // ----------------------------------------------------------------
  reg [15:0] slow_cnt;
  always @(posedge sys_clk_in)
  begin
    if (int_rst)
    begin
      slow_cnt         <= 16'h0000;
      mac_fast_clk_out <= 1'b0;
    end
    else
    begin
      if (slow_cnt != SLOW_CYCLES[15:0])
        slow_cnt <= slow_cnt + 16'h0001;
      mac_fast_clk_out <= (slow_cnt == SLOW_CYCLES[15:0]) && an_en;
    end
  end

  // ----------------------------------------------------------------
  // Receive carrier detection
  // ----------------------------------------------------------------
  localparam SYM_J    = 5'h18;
  localparam SYM_K    = 5'h11;
  localparam SYM_T    = 5'h0D;
  localparam SYM_R    = 5'h07;
  localparam SYM_IDLE = 5'h1F;
  localparam C_IDLE = 3'h0;
  localparam C_PRE  = 3'h1;
  localparam C_GOTJ = 3'h2;
  localparam C_PKT  = 3'h3;
  localparam C_GOTT = 3'h4;
  localparam C_GOTI = 3'h5;
  reg [2:0] cs;
  reg [2:0] next_cs;
  reg [9:0] win;
  reg [3:0] ones;
  reg       rx_crs;
  reg       next_rx_crs;
  // Two zeros, adjacent or not, anywhere in ten bits
  wire [9:0] nwin = {win[8:0], rx_bit};
  wire [9:0] zeros = ~nwin;
  wire two_zero = (zeros & (zeros - 10'h001)) != 10'h000 &&
                  !((zeros & (zeros >> 1)) != 10'h000 && (zeros & (zeros - 10'h001) &
                    (zeros - 10'h001 - ((zeros & (zeros - 10'h001)) & ~(zeros - 10'h001))))
                    == 10'h000);
  always @*
  begin
    next_cs     = cs;
    next_rx_crs = rx_crs;
    case (cs)
      C_IDLE:
        if (two_zero)
        begin
          next_cs     = C_PRE;
          next_rx_crs = 1'b1;
        end
      C_PRE:
        if (ones == 4'h9 && rx_bit)
        begin
          next_cs     = C_IDLE;
          next_rx_crs = 1'b0;
        end
        else if (sym_vld && sym_q2 == SYM_J)
          next_cs = C_GOTJ;
      C_GOTJ:
        if (sym_vld)
          next_cs = (sym_q2 == SYM_K) ? C_PKT : C_PRE;
      C_PKT:
        if (sym_vld && sym_q2 == SYM_T)
        begin
          next_cs     = C_GOTT;
          next_rx_crs = 1'b0;
        end
        else if (sym_vld && sym_q2 == SYM_IDLE)
        begin
          next_cs     = C_GOTI;
          next_rx_crs = 1'b0;
        end
      C_GOTT:
        if (sym_vld)
        begin
          next_cs     = (sym_q2 == SYM_R) ? C_IDLE : C_PKT;
          next_rx_crs = (sym_q2 != SYM_R);
        end
      C_GOTI:
        if (sym_vld)
        begin
          next_cs     = (sym_q2 == SYM_IDLE) ? C_IDLE : C_PKT;
          next_rx_crs = (sym_q2 != SYM_IDLE);
        end
      default:
        next_cs = C_IDLE;
    endcase
  end
  always @(posedge sys_clk_in)
  begin
    if (int_rst)
    begin
      cs     <= C_IDLE;
      win    <= 10'h3FF;
      ones   <= 4'h0;
      rx_crs <= 1'b0;
    end
    else
    begin
      cs     <= next_cs;
      win    <= nwin;
      ones   <= rx_bit ? ((ones == 4'hF) ? ones : ones + 4'h1) : 4'h0;
      rx_crs <= next_rx_crs;
    end
  end

  // ----------------------------------------------------------------
  // Link monitor
  // ----------------------------------------------------------------
  localparam L_DOWN  = 2'h0;
  localparam L_WAIT  = 2'h1;
  localparam L_READY = 2'h2;
  localparam L_UP    = 2'h3;
  reg [1:0]  ls;
  reg [15:0] settle;
  always @(posedge sys_clk_in)
  begin
    if (int_rst || !dvalid)
    begin
      ls     <= L_DOWN;
      settle <= 16'h0000;
    end
    else
    begin
      case (ls)
        L_DOWN:
          ls <= L_WAIT;
        L_WAIT:
          if (settle == SETTLE_CYCLES[15:0] - 16'h0001)
            ls <= an_en ? L_READY : L_UP;
          else
            settle <= settle + 16'h0001;
        L_READY:
          if (an_ok)
            ls <= L_UP;
        default:
          ls <= L_UP;
      endcase
    end
  end
  wire link100 = (ls == L_UP);
  wire link    = spd100 ? link100 : link10;
  assign status = {5'h00, rx_crs, (ls == L_UP) | (ls == L_READY), link};

  // ----------------------------------------------------------------
  // Carrier, collision and loopback outputs
  // ----------------------------------------------------------------
  // Collision test counts bit times in system clocks at the current speed
  reg [12:0] ct_cnt;
  wire [12:0] bit_clks = spd100 ? 13'h0001 : 13'h000A;
  wire rx_act = near_lb ? tx_en : rx_crs;
  wire tx_act = tx_en && !far_lb;
  always @(posedge sys_clk_in)
  begin
    if (int_rst || !tx_en)
      ct_cnt <= 13'h0000;
    else if (ct_cnt != 13'h1FFF)
      ct_cnt <= ct_cnt + 13'h0001;
  end
  wire col_tst = col_test && tx_en && ct_cnt >= bit_clks;
  always @(posedge sys_clk_in)
  begin
    if (int_rst)
    begin
      crs_out                   <= 1'b0;
      crs_dv_out                <= 1'b0;
      col_out                   <= 1'b0;
      rxd_out                   <= 4'h0;
      line_txd_out              <= 4'h0;
      line_tx_power_out         <= 1'b0;
      link_indicator_output_out <= 1'b0;
      mac_isolate_out           <= 1'b0;
    end
    else
    begin
      crs_out    <= !rmii_sel && !far_lb &&
                    ((fdx || rptr) ? rx_act : (rx_act || tx_act));
      crs_dv_out <= rmii_sel && !far_lb &&
                    ((fdx || rptr) ? rx_act : (rx_act || tx_act));
      // Full duplex masks collision even under collision test
      if (col_tst && !fdx)
        col_out <= 1'b1;
      else
        col_out <= !fdx && !near_lb && !far_lb && tx_en && rx_crs;
      rxd_out           <= far_lb ? 4'h0 : (near_lb ? txd_in : rx_line_data_in);
      line_txd_out      <= far_lb ? rx_line_data_in : txd_in;
      line_tx_power_out <= !near_lb;
      link_indicator_output_out <= link;
      mac_isolate_out   <= far_lb;
    end
  end
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      in_reset_out <= 1'b1;
    else
      in_reset_out <= int_rst;
  end
endmodule
`default_nettype wire

// File: hdl/phy_ctl_regs.vh
// Purpose: constants for the transceiver reset, carrier, collision, link and loopback control
// Assumes: 100 MHz system clock
// Notes:   all offsets and counts as macros
`ifndef PHY_CTL_REGS_VH
`define PHY_CTL_REGS_VH
`define ADDR_CTRL        4'h0
`define ADDR_MODE        4'h1
`define ADDR_STAT        4'h2
`define CTRL_SOFT_RESET  0
`define CTRL_COL_TEST    1
`define CTRL_LOOPBACK    2
`define CTRL_AN_ENABLE   3
`define CTRL_FULL_DUPLEX 4
`define CTRL_SPEED_100   5
`define CTRL_REPEATER    6
`define MODE_REMOTE_LOOP 0
`define MODE_USER_BITS   4
`define CTRL_RESET_VAL   8'h28
`define MODE_RESET_VAL   8'h00
`define SLOW_TIME_NS     16000
`define SETTLE_TIME_NS   330000
`define SRST_MAX_NS      500000000
`define CLK_PERIOD_NS    10
`define SLOW_CYCLES      (`SLOW_TIME_NS / `CLK_PERIOD_NS)
`define SETTLE_CYCLES    ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SRST_CYCLES      4
`endif

// File: dv/mac_model.sv
// Purpose: MAC side partner: reset pin driver and transmit frames
// Assumes: driven from the bench clock
// Notes:   idle data inverts so stale nibbles never pass
`timescale 1ns/1ps
`default_nettype none
module mac_model (
  input  wire logic       clk_in,
  output var  logic       hw_reset_low_pin_out,
  output var  logic       tx_en_out,
  output var  logic [3:0] txd_out
);
  initial
  begin
    hw_reset_low_pin_out = 1'b1;
    tx_en_out = 1'b0;
    txd_out = 4'h0;
  end
  // Eight edges low: well past the two-flop synchroniser
  task automatic pin_reset();
  begin
    @(posedge clk_in);
    hw_reset_low_pin_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    hw_reset_low_pin_out <= 1'b1;
  end
  endtask
  task automatic send(input int n);
    int k;
  begin
    for (k = 0; k < n; k++)
    begin
      @(posedge clk_in);
      tx_en_out <= 1'b1;
      txd_out <= 4'($urandom);
    end
    @(posedge clk_in);
    tx_en_out <= 1'b0;
    txd_out <= ~txd_out;
  end
  endtask
endmodule
`default_nettype wire

// File: dv/phy_ctl_checker.sv
// Purpose: port checks on reset, link, collision and loopback
// Assumes: bound to the top module
// Notes:   control bits mirrored from writes, may lag one cycle
`timescale 1ns/1ps
`default_nettype none
module phy_ctl_checker #(
  parameter SETTLE_CYCLES = 20
) (
  input wire logic       sys_clk_in,
  input wire logic       rstn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reduced_iface_strap_in,
  input wire logic       tx_en_in,
  input wire logic       data_valid_in,
  input wire logic       link10_in,
  input wire logic       col_out,
  input wire logic       line_tx_power_out,
  input wire logic       link_indicator_output_out,
  input wire logic       mac_isolate_out,
  input wire logic       in_reset_out
);
  logic [7:0]  ctrl;
  logic [15:0] vcnt;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in || in_reset_out)
      ctrl <= 8'h28;
    else if (reg_wr_in && reg_addr_in == 4'h0)
      ctrl <= reg_wdata_in;
    vcnt <= data_valid_in ? vcnt + {15'h0000, vcnt != 16'hFFFF} : 16'h0000;
  end
  sequence sr_write;
    reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[0];
  endsequence
  sequence far_write;
    reg_wr_in && reg_addr_in == 4'h1 && reg_wdata_in[0] && reduced_iface_strap_in;
  endsequence
  soft_reset_start_a: assert property (sr_write |-> ##[1:8] in_reset_out)
    else $error("soft reset did not start");
  reset_quiet_a: assert property (in_reset_out |=> !link_indicator_output_out
    && !mac_isolate_out && !col_out) else $error("output active in reset");
  link_drop_a: assert property ((!data_valid_in && !link10_in)[*4]
    |=> !link_indicator_output_out) else $error("link held without valid");
  settle_wait_a: assert property ($rose(link_indicator_output_out) && ctrl[5]
    |-> vcnt >= SETTLE_CYCLES) else $error("link before settle time");
  col_duplex_a: assert property (ctrl[4][*4] |-> !col_out)
    else $error("collision in full duplex");
  col_loop_a: assert property ((ctrl[2] && !ctrl[1])[*4] |-> !col_out)
    else $error("collision in loopback");
  tx_power_a: assert property (ctrl[2][*4] |-> !line_tx_power_out)
    else $error("transmitter on in loopback");
  far_iso_a: assert property (far_write |-> ##[1:6] mac_isolate_out)
    else $error("far loopback did not isolate");
  far_rmii_a: assert property ((!reduced_iface_strap_in)[*4] |-> !mac_isolate_out)
    else $error("far loopback outside RMII");
  col_test_a: assert property ($rose(tx_en_in) && ctrl[1] && !ctrl[4]
    |-> ##[1:520] col_out) else $error("collision test late");
endmodule
bind phy_reset_carrier_link_loopback phy_ctl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .tx_en_in(tx_en_in),
  .reduced_iface_strap_in(reduced_iface_strap_in), .data_valid_in(data_valid_in),
  .link10_in(link10_in), .col_out(col_out), .line_tx_power_out(line_tx_power_out),
  .link_indicator_output_out(link_indicator_output_out),
  .mac_isolate_out(mac_isolate_out), .in_reset_out(in_reset_out));
`default_nettype wire

// File: dv/tb.sv
// Purpose: self-checking bench for the transceiver control block
// Assumes: 100 MHz clock, shortened settle and slow counts
// Notes:   RMII strap high unless a step says otherwise
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SC = 20;
  logic       clk, rstn, wr, rd, strap, dv, l10, anl, rx_act, rx_bit;
  logic [3:0] addr, a;
  logic [7:0] wdata, v;
  wire  [7:0] rdata;
  wire  [3:0] txd;
  wire        pin, tx_en, crs, crs_dv, col, pwr, link, iso, fast, inrst;
  int         n_mismatch = 0, samples_checked = 0, i;
  mac_model mac (.clk_in(clk), .hw_reset_low_pin_out(pin), .tx_en_out(tx_en), .txd_out(txd));
  phy_reset_carrier_link_loopback #(.SETTLE_CYCLES(SC), .SLOW_CYCLES(SC)) uut (
    .sys_clk_in(clk), .rstn_in(rstn), .hw_reset_low_pin_in(pin), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reduced_iface_strap_in(strap), .tx_en_in(tx_en), .txd_in(txd), .rx_bit_in(rx_bit),
    .rx_sym_valid_in(1'b0), .rx_sym_in(5'h00), .rx_line_data_in(4'h0), .data_valid_in(dv),
    .link10_in(l10), .an_enable_link_in(anl), .crs_out(crs), .crs_dv_out(crs_dv),
    .col_out(col), .rxd_out(), .line_txd_out(), .line_tx_power_out(pwr),
    .link_indicator_output_out(link), .mac_isolate_out(iso), .mac_fast_clk_out(fast),
    .in_reset_out(inrst));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk; // Never stops, also in reset
  end
  // Line bits toggle every 80 ns while active, all ones otherwise
  always @(posedge clk)
    rx_bit <= !rx_act || (($time % 160) < 80);
  function automatic logic [7:0] rb(input logic [3:0] ad, input logic [7:0] d);
    return ad == 4'h0 ? d & 8'h7E : ad == 4'h1 ? d & 8'hF1 : 8'h00;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
  begin
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task automatic rreg(input logic [3:0] ad, input logic [7:0] e);
  begin
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  end
  endtask
  // Output is picked after the wait, not when the task is called
  function automatic logic [7:0] pick(input int s);
    return s == 0 ? 8'(fast) : s == 1 ? 8'(link) : s == 2 ? {5'h00, pwr, crs_dv, col} :
           s == 3 ? 8'(col) : s == 4 ? 8'(crs_dv) : s == 5 ? 8'(crs) : 8'(iso);
  endfunction
  task automatic wait_chk(input int n, input int sel, input logic [7:0] e);
  begin
    repeat (n) @(posedge clk);
    #1 chk(pick(sel), e);
  end
  endtask
  task automatic test_done();
  begin
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    i = $urandom(97783);
    {rstn, wr, rd, dv, l10, anl, rx_act, rx_bit} = 8'h01;
    {addr, wdata, strap} = 13'h0001;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rreg(4'h0, 8'h28);
    for (i = 0; i < 12; i++)
    begin
      a = 4'($urandom_range(0, 4));
      v = rb(a == 4'h2 ? 4'h1 : a, 8'($urandom));
      wreg(a, v);
      rreg(a, rb(a, v));
    end
    wreg(4'h1, 8'hF1);
    wreg(4'h0, 8'h29);
    repeat (12) @(posedge clk);
    rreg(4'h0, 8'h28);
    rreg(4'h1, 8'hF0);
    mac.pin_reset();
    wait_chk(5, 0, 8'h00);
    rreg(4'h1, 8'h00);
    wait_chk(SC + 5, 0, 8'h01);
    dv <= 1'b1;
    repeat (SC + 10) @(posedge clk);
    rreg(4'h2, 8'h02);
    anl <= 1'b1;
    wait_chk(6, 1, 8'h01);
    @(posedge clk);
    dv <= 1'b0;
    wait_chk(4, 1, 8'h00);
    wreg(4'h0, 8'h20);
    dv <= 1'b1;
    anl <= 1'b0;
    wait_chk(SC + 10, 1, 8'h01);
    wreg(4'h0, 8'h00);
    l10 <= 1'b1;
    dv <= 1'b0;
    wait_chk(8, 1, 8'h01);
    l10 <= 1'b0;
    wait_chk(6, 1, 8'h00);
    // Collision test, full duplex and loopback each carry one frame
    for (i = 0; i < 3; i++)
    begin
      v = i == 0 ? 8'h22 : i == 1 ? 8'h32 : 8'h24;
      wreg(4'h0, v);
      fork
        mac.send(40);
      join_none
      v = i == 0 ? 8'h07 : i == 1 ? 8'h04 : 8'h02;
      wait_chk(30, 2, v);
      wait_chk(25, 3, 8'h00);
    end
    wreg(4'h0, 8'h30);
    rx_act <= 1'b1;
    wait_chk(40, 4, 8'h01);
    strap <= 1'b0;
    wait_chk(8, 5, 8'h01);
    rx_act <= 1'b0;
    wait_chk(30, 5, 8'h00);
    wreg(4'h1, 8'h01);
    wait_chk(6, 6, 8'h00);
    strap <= 1'b1;
    wreg(4'h1, 8'h01);
    wait_chk(6, 6, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
